// ==== common/shift_port_params.svh ====
// Register offsets, field positions, reset values and counts of the shift port
`ifndef SHIFT_PORT_PARAMS_SVH
`define SHIFT_PORT_PARAMS_SVH

`define ADDR_SHIFT_DATA     8'h9a
`define ADDR_TWO_WIRE_DATA  8'h9b
`define ADDR_SHIFT_CTRL     8'h9c
`define ADDR_SHIFT_STATUS   8'h9d
`define ADDR_TWO_WIRE_CTRL  8'h9e
`define ADDR_POWER_CTRL     8'hf1
`define ADDR_CLK_SRC_SEL    8'hf2

`define CTRL_CPOL           0
`define CTRL_CPHA           1
`define CTRL_MASTER         2
`define CTRL_SS_EN          3

`define TW_ONE_BIT          0
`define TW_I2C_MODE         1
`define TW_LSB_FIRST        2

`define PWR_SPI_PD          0

`define CLKSEL_SRC_MSB      2
`define CLKSEL_SW_SCK       3

`define STAT_COUNT_FLAG     4
`define STAT_START_STOP     5
`define STAT_FIFO_FULL      6
`define STAT_STRETCH        7

`define RST_POWER_DOWN      1'b1
`define RST_SW_SCK          1'b0

`define FULL_COUNT          4'h8
`define ONE_COUNT           4'h1

`endif

// ==== common/shift_port_pkg.sv ====
// Types shared by the shift port design
package shift_port_pkg;

  typedef enum logic [2:0] {
    SRC_SOFT      = 3'b000,
    SRC_WR_PULSE  = 3'b001,
    SRC_WR_TOGGLE = 3'b010,
    SRC_T0_PULSE  = 3'b011,
    SRC_T0_TOGGLE = 3'b100,
    SRC_T1_PULSE  = 3'b101,
    SRC_T1_TOGGLE = 3'b110
  } sck_source_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic       wrEn;
    logic       rdEn;
  } sfr_req_type;

  typedef struct packed {
    logic ssEnable;
    logic master;
    logic cpha;
    logic cpol;
  } spi_mode_type;

  typedef struct packed {
    logic lsbFirst;
    logic i2cMode;
    logic oneBitCount;
  } wire_mode_type;

endpackage

// ==== design/spi_i2c_shift_port.sv ====
// Shared SPI / two-wire serial shift port with transmit FIFO and SFR access
//
// Functional notes
// RULE1 - SPI master/slave, duplex, CPOL, CPHA, order, select
// RULE2 - Receive on data in, transmit on data out
// RULE3 - Master drives clock from software or selected source
// RULE4 - Write strobe source: one low pulse per write
// RULE5 - Write toggle source: clock flips per write
// RULE6 - Timer pulse source: one high pulse per overflow
// RULE7 - Timer toggle source: clock flips per overflow
// RULE8 - Select high blocks shifting and counting
// RULE9 - Master holds select low through transaction; the port has no select output
// RULE10 - Slave drives data out only while selected
// RULE11 - Count interrupt when bit counter reaches eight
// RULE12 - Data register access clears count interrupt
// RULE13 - Bit counter readable in control register
// RULE14 - Power-down bit releases pins, disables port
// RULE15 - Unread byte: next transfer drops flag, overwrites
// RULE16 - Board joins data pins into open-drain line
// RULE17 - Start or stop sets separate interrupt
// RULE18 - Two-wire count on falling edge, reset events
// RULE19 - Count select: eight bits or one bit
// RULE20 - Hold clock low after count until written
// RULE21 - One-bit mode waits for acknowledge latch
// RULE22 - Two-wire: any rate, stretching, general call
// RULE23 - Two-wire data captured on rising clock
// RULE24 - Data write clears interrupt, releases clock
// RULE25 - One eight-bit register shifts both directions
`timescale 1ns/1ps
`include "shift_port_params.svh"

module shift_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // Filling side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output      logic             inReady,
  // Draining side
  output      logic             outValid,
  output      logic [WIDTH-1:0] outData,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_r;
  logic [AW-1:0]    rdPtr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign inReady  = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData  = mem[rdPtr_r];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wrPtr_r <= (wrPtr_r == AW'(DEPTH - 1)) ? '0 : AW'(wrPtr_r + 1'b1);
      end
      if (pop) begin
        rdPtr_r <= (rdPtr_r == AW'(DEPTH - 1)) ? '0 : AW'(rdPtr_r + 1'b1);
      end
      if (push && !pop) begin
        count_r <= (AW+1)'(count_r + 1'b1);
      end else if (pop && !push) begin
        count_r <= (AW+1)'(count_r - 1'b1);
      end
    end
  end
endmodule

module spi_i2c_shift_port
  import shift_port_pkg::*;
#(
  parameter int FIFO_WIDTH = 8,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Special function register port
  input  wire sfr_req_type sfrReq,
  output      logic [7:0]  sfrRdData,
  // Same-domain clock sources
  input  wire logic        timer0OverflowOut,
  input  wire logic        timer1OverflowOut,
  input  wire logic        externalDataMove,
  // Serial clock pin
  input  wire logic        sckIn,
  output      logic        sckOut,
  output      logic        sckOe,
  // Serial data and select pins
  input  wire logic        dataIn,
  output      logic        dataOut,
  output      logic        dataOe,
  input  wire logic        slaveSelectIn_n,
  // Status
  output      logic        countInterrupt,
  output      logic        startStopInterrupt,
  output      logic        txReady,
  output      logic        portActive
);

  spi_mode_type  spiMode_r;
  wire_mode_type wireMode_r;
  sck_source_type srcSel_r;
  logic          swSck_r;
  logic          powerDown_r;

  logic [2:0]    syncA_r;
  logic [2:0]    syncB_r;
  logic          sckS;
  logic          dinS;
  logic          ssS_n;
  logic          sckLast_r;
  logic          dinLast_r;
  logic          sckGen_r;

  logic [7:0]    shiftReg_r;
  logic [7:0]    rxData_r;
  logic [3:0]    bitCnt_r;
  logic          doutBit_r;
  logic          loaded_r;
  logic          countFlag_r;
  logic          startStopFlag_r;
  logic          stretch_r;
  logic          sckOut_r;
  logic          sckOe_r;
  logic          dataOut_r;
  logic          dataOe_r;
  logic          txReady_r;
  logic          portActive_r;
  logic [7:0]    sfrRdData_r;

  logic          dataWrite;
  logic          dataAccess;
  logic          sckNow;
  logic          rise;
  logic          fall;
  logic          leading;
  logic          trailing;
  logic          sampleEdge;
  logic          shiftEdge;
  logic          countEdge;
  logic          active;
  logic [3:0]    limit;
  logic [3:0]    cntNxt;
  logic          countHit;
  logic          startStop;
  logic [7:0]    shiftedIn;
  logic          fifoInReady;
  logic          fifoOutValid;
  logic [7:0]    fifoOutData;
  logic          loadNow;

  // Register port decode
  assign dataWrite  = sfrReq.wrEn && (sfrReq.addr == `ADDR_SHIFT_DATA ||
                                      sfrReq.addr == `ADDR_TWO_WIRE_DATA);
  assign dataAccess = (sfrReq.wrEn || sfrReq.rdEn) &&
                      (sfrReq.addr == `ADDR_SHIFT_DATA ||
                       sfrReq.addr == `ADDR_TWO_WIRE_DATA);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      spiMode_r   <= '0;
      wireMode_r  <= '0;
      srcSel_r    <= SRC_SOFT;
      swSck_r     <= `RST_SW_SCK;
      powerDown_r <= `RST_POWER_DOWN;
    end else if (sfrReq.wrEn) begin
      unique case (sfrReq.addr)
        `ADDR_SHIFT_CTRL: begin
          spiMode_r.cpol     <= sfrReq.wrData[`CTRL_CPOL];     // see RULE1
          spiMode_r.cpha     <= sfrReq.wrData[`CTRL_CPHA];
          spiMode_r.master   <= sfrReq.wrData[`CTRL_MASTER];
          spiMode_r.ssEnable <= sfrReq.wrData[`CTRL_SS_EN];
        end
        `ADDR_TWO_WIRE_CTRL: begin
          wireMode_r.oneBitCount <= sfrReq.wrData[`TW_ONE_BIT]; // see RULE19
          wireMode_r.i2cMode     <= sfrReq.wrData[`TW_I2C_MODE];
          wireMode_r.lsbFirst    <= sfrReq.wrData[`TW_LSB_FIRST];
        end
        `ADDR_POWER_CTRL: begin
          powerDown_r <= sfrReq.wrData[`PWR_SPI_PD];           // see RULE14
        end
        `ADDR_CLK_SRC_SEL: begin
          srcSel_r <= sck_source_type'(sfrReq.wrData[`CLKSEL_SRC_MSB:0]);
          swSck_r  <= sfrReq.wrData[`CLKSEL_SW_SCK];
        end
        default: begin
        end
      endcase
    end
  end

  // Pin synchronisers; only the second stage is ever read
  always_ff @(posedge core_clk) begin
    if (rst) begin
      syncA_r <= 3'h7;
      syncB_r <= 3'h7;
    end else begin
      syncA_r <= {sckIn, dataIn, slaveSelectIn_n};
      syncB_r <= syncA_r;
    end
  end

  assign sckS  = syncB_r[2];
  assign dinS  = syncB_r[1];
  assign ssS_n = syncB_r[0];

  // Master clock generator
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sckGen_r <= 1'b0;
    end else begin
      unique case (srcSel_r)
        SRC_SOFT:      sckGen_r <= swSck_r;                       // see RULE3
        SRC_WR_PULSE:  sckGen_r <= !externalDataMove;             // see RULE4
        SRC_WR_TOGGLE: sckGen_r <= sckGen_r ^ externalDataMove;   // see RULE5
        SRC_T0_PULSE:  sckGen_r <= timer0OverflowOut;             // see RULE6
        SRC_T0_TOGGLE: sckGen_r <= sckGen_r ^ timer0OverflowOut;  // see RULE7
        SRC_T1_PULSE:  sckGen_r <= timer1OverflowOut;             // see RULE6
        SRC_T1_TOGGLE: sckGen_r <= sckGen_r ^ timer1OverflowOut;  // see RULE7
        default:       sckGen_r <= spiMode_r.cpol;
      endcase
    end
  end

  // Edge detection; two-wire always watches the bus itself
  assign sckNow = (spiMode_r.master && !wireMode_r.i2cMode) ? sckGen_r : sckS;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sckLast_r <= 1'b1; // Matches synchroniser reset, no false edge
      dinLast_r <= 1'b1;
    end else begin
      sckLast_r <= sckNow;
      dinLast_r <= dinS;
    end
  end

  assign rise     = sckNow && !sckLast_r;
  assign fall     = !sckNow && sckLast_r;
  assign leading  = spiMode_r.cpol ? fall : rise;
  assign trailing = spiMode_r.cpol ? rise : fall;
  assign sampleEdge = wireMode_r.i2cMode ? rise                    // see RULE23
                    : (spiMode_r.cpha ? trailing : leading);       // see RULE1
  assign shiftEdge  = wireMode_r.i2cMode ? fall
                    : (spiMode_r.cpha ? leading : trailing);
  assign countEdge  = wireMode_r.i2cMode ? fall : sampleEdge;      // see RULE18

  // With select enabled, select high freezes the SPI shifter, whatever the role
  assign active = !powerDown_r &&
                  !(spiMode_r.ssEnable && ssS_n && !wireMode_r.i2cMode); // see RULE8

  assign limit  = (wireMode_r.i2cMode && wireMode_r.oneBitCount) ? `ONE_COUNT
                                                                   : `FULL_COUNT;
  assign cntNxt = (bitCnt_r >= limit) ? `ONE_COUNT : 4'(bitCnt_r + 4'h1);
  assign countHit = countEdge && active && (cntNxt == limit);     // see RULE11
  assign startStop = wireMode_r.i2cMode && !powerDown_r && sckS && sckLast_r &&
                     (dinS != dinLast_r);                         // see RULE17
  assign shiftedIn = wireMode_r.lsbFirst ? {dinS, shiftReg_r[7:1]}
                                         : {shiftReg_r[6:0], dinS};

  // Loading waits for a quiet cycle so an edge is never lost
  assign loadNow = fifoOutValid && !loaded_r && !powerDown_r &&
                   !sampleEdge && !shiftEdge;

  shift_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) txFifo (
    .core_clk (core_clk),
    .rst      (rst),
    .inValid  (dataWrite),
    .inData   (sfrReq.wrData),
    .inReady  (fifoInReady),
    .outValid (fifoOutValid),
    .outData  (fifoOutData),
    .outReady (loadNow)
  );

  // Single shift register for both directions
  always_ff @(posedge core_clk) begin
    if (rst) begin
      shiftReg_r <= 8'h00;
      doutBit_r  <= 1'b1;
      loaded_r   <= 1'b0;
    end else if (loadNow) begin
      shiftReg_r <= fifoOutData;                                   // see RULE25
      doutBit_r  <= wireMode_r.lsbFirst ? fifoOutData[0] : fifoOutData[7];
      loaded_r   <= 1'b1;
    end else begin
      if (sampleEdge && active) begin
        shiftReg_r <= shiftedIn;                                   // see RULE2
      end
      if (countHit && wireMode_r.i2cMode) begin
        doutBit_r <= 1'b1;
      end else if (shiftEdge && active) begin
        doutBit_r <= wireMode_r.lsbFirst ? shiftReg_r[0] : shiftReg_r[7];
      end
      if (countHit) begin
        loaded_r <= 1'b0;
      end
    end
  end

  // Received byte is simply overwritten by the next one
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rxData_r <= 8'h00;
    end else if (countHit) begin
      rxData_r <= wireMode_r.i2cMode ? shiftReg_r : shiftedIn;     // see RULE15
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || powerDown_r) begin
      bitCnt_r <= 4'h0;
    end else if (wireMode_r.i2cMode && (dataAccess || startStop)) begin
      bitCnt_r <= 4'h0;                                            // see RULE18
    end else if (countEdge && active) begin
      bitCnt_r <= cntNxt;
    end
  end

  // Flags: a new event beats a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst || powerDown_r) begin
      countFlag_r <= 1'b0;
    end else if (countHit) begin
      countFlag_r <= 1'b1;                                         // see RULE21
    end else if (dataAccess) begin
      countFlag_r <= 1'b0;                                         // see RULE12
    end else if (countEdge && active) begin
      countFlag_r <= 1'b0;                                         // see RULE15
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || powerDown_r) begin
      startStopFlag_r <= 1'b0;
    end else if (startStop) begin
      startStopFlag_r <= 1'b1;
    end else if (sfrReq.rdEn && sfrReq.addr == `ADDR_TWO_WIRE_CTRL) begin
      startStopFlag_r <= 1'b0;
    end
  end

  // Clock held low until software's byte reaches the shifter
  always_ff @(posedge core_clk) begin
    if (rst || powerDown_r) begin
      stretch_r <= 1'b0;
    end else if (countHit && wireMode_r.i2cMode) begin
      stretch_r <= 1'b1;                                           // see RULE20
    end else if (loadNow) begin
      stretch_r <= 1'b0;                                           // see RULE24
    end
  end

  // Pin drive; open-drain lines only ever pull low
  always_ff @(posedge core_clk) begin
    if (rst || powerDown_r) begin
      sckOut_r  <= 1'b0;
      sckOe_r   <= 1'b0;                                           // see RULE14
      dataOut_r <= 1'b0;
      dataOe_r  <= 1'b0;
    end else if (wireMode_r.i2cMode) begin
      sckOut_r  <= 1'b0;
      sckOe_r   <= stretch_r || (spiMode_r.master && !sckGen_r);   // see RULE22
      dataOut_r <= 1'b0;
      dataOe_r  <= !doutBit_r;
    end else begin
      sckOut_r  <= sckGen_r;
      sckOe_r   <= spiMode_r.master;                               // see RULE3
      dataOut_r <= doutBit_r;
      dataOe_r  <= spiMode_r.master || !spiMode_r.ssEnable || !ssS_n; // see RULE10
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      txReady_r    <= 1'b0;
      portActive_r <= 1'b0;
    end else begin
      txReady_r    <= fifoInReady;
      portActive_r <= !powerDown_r;
    end
  end

  // Read data; unmapped offsets read zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sfrRdData_r <= 8'h00;
    end else if (sfrReq.rdEn) begin
      unique case (sfrReq.addr)
        `ADDR_SHIFT_DATA, `ADDR_TWO_WIRE_DATA: sfrRdData_r <= rxData_r;
        `ADDR_SHIFT_CTRL:    sfrRdData_r <= {bitCnt_r, spiMode_r};  // see RULE13
        `ADDR_SHIFT_STATUS:  sfrRdData_r <= {stretch_r, !fifoInReady, startStopFlag_r,
                                             countFlag_r, bitCnt_r};
        `ADDR_TWO_WIRE_CTRL: sfrRdData_r <= {5'h00, wireMode_r};
        `ADDR_POWER_CTRL:    sfrRdData_r <= {7'h00, powerDown_r};
        `ADDR_CLK_SRC_SEL:   sfrRdData_r <= {4'h0, swSck_r, srcSel_r};
        default:             sfrRdData_r <= 8'h00;
      endcase
    end
  end

  assign sfrRdData          = sfrRdData_r;
  assign sckOut             = sckOut_r;
  assign sckOe              = sckOe_r;
  assign dataOut            = dataOut_r;
  assign dataOe             = dataOe_r;
  assign countInterrupt     = countFlag_r;
  assign startStopInterrupt = startStopFlag_r;
  assign txReady            = txReady_r;
  assign portActive         = portActive_r;

endmodule

// ==== verif/shift_port_sva.sv ====
// Port-level checker of the shift port
`timescale 1ns/1ps
`include "shift_port_params.svh"
module shift_port_sva
  import shift_port_pkg::*;
(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // Register port
  input wire sfr_req_type sfrReq,
  input wire logic [7:0]  sfrRdData,
  // Clock sources
  input wire logic        timer0OverflowOut,
  input wire logic        timer1OverflowOut,
  input wire logic        externalDataMove,
  // Serial pins
  input wire logic        sckIn,
  input wire logic        sckOut,
  input wire logic        sckOe,
  input wire logic        dataIn,
  input wire logic        dataOut,
  input wire logic        dataOe,
  input wire logic        slaveSelectIn_n,
  // Status
  input wire logic        countInterrupt,
  input wire logic        startStopInterrupt,
  input wire logic        txReady,
  input wire logic        portActive
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // Pin edges land 3 cycles late, so hold checks wait for a quiet clock pin
  logic       sckPrev_r;
  logic [2:0] sckStill_r;
  always_ff @(posedge core_clk) begin
    sckPrev_r <= sckIn;
    if (rst || sckIn != sckPrev_r) begin
      sckStill_r <= 3'h0;
    end else if (sckStill_r != 3'h7) begin
      sckStill_r <= sckStill_r + 3'h1;
    end
  end

  property p_pd_write;
    logic pd;
    (sfrReq.wrEn && sfrReq.addr == `ADDR_POWER_CTRL, pd = sfrReq.wrData[`PWR_SPI_PD])
      |-> ##2 (portActive == !pd);
  endproperty

  a_pd_pins_off: assert property (!portActive && !$past(portActive) |-> !sckOe && !dataOe)
    else $error("pins driven while powered down");
  a_pd_write_takes: assert property (p_pd_write)
    else $error("power-down bit not reflected");
  a_rd_unmapped_zero: assert property (sfrReq.rdEn && sfrReq.addr == 8'h00 |=> sfrRdData == 8'h00)
    else $error("unmapped read not zero");
  a_rd_data_stands: assert property (!sfrReq.rdEn |=> $stable(sfrRdData))
    else $error("read data moved without a read");
  a_count_read_clear: assert property (countInterrupt && sfrReq.rdEn && (sfrReq.addr ==
    `ADDR_SHIFT_DATA || sfrReq.addr == `ADDR_TWO_WIRE_DATA) |=> !countInterrupt)
    else $error("count flag survived data read");
  a_count_flag_holds: assert property (countInterrupt && !sckOe && sckStill_r == 3'h7 &&
    !sfrReq.rdEn && !sfrReq.wrEn |=> countInterrupt)
    else $error("count flag dropped with no cause");
  a_count_needs_power: assert property ($rose(countInterrupt) |-> portActive)
    else $error("count flag rose while powered down");
  a_startstop_clear: assert property (startStopInterrupt && sfrReq.rdEn &&
    sfrReq.addr == `ADDR_TWO_WIRE_CTRL |=> !startStopInterrupt)
    else $error("start/stop flag survived read");

  cover property ($rose(countInterrupt));
  cover property ($rose(startStopInterrupt));
  cover property ($fell(txReady));
endmodule

bind spi_i2c_shift_port shift_port_sva i_sva (
  .core_clk(core_clk), .rst(rst), .sfrReq(sfrReq), .sfrRdData(sfrRdData),
  .timer0OverflowOut(timer0OverflowOut), .timer1OverflowOut(timer1OverflowOut),
  .externalDataMove(externalDataMove), .sckIn(sckIn), .sckOut(sckOut), .sckOe(sckOe),
  .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .slaveSelectIn_n(slaveSelectIn_n),
  .countInterrupt(countInterrupt), .startStopInterrupt(startStopInterrupt),
  .txReady(txReady), .portActive(portActive));

// ==== verif/spi_far_master.sv ====
// External serial master driving the port's pins
`timescale 1ns/1ps
module spi_far_master (
  // Pins toward the port
  output logic      sck,
  output logic      mosi,
  output logic      selN,
  input  wire logic miso,
  input  wire logic misoOe
);
  localparam time HALF = 32;

  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    selN = 1'b1;
  end

  task automatic select(input logic on);
    selN = !on;
    #(HALF);
  endtask

  // Clock stands still between frames, mode 0 only
  task automatic exchange(input logic [7:0] tx, input int first, input int n,
                          input logic lsb, output logic [7:0] rx, output logic oe);
    int k;
    rx = 8'h00;
    oe = 1'b1;
    for (int i = first; i < first + n; i++) begin
      k = lsb ? i : 7 - i;
      mosi = tx[k];
      #(HALF);
      sck = 1'b1;
      rx[k] = misoOe ? miso : ~miso; // Released line shows no stale bit
      oe = oe & misoOe;
      #(HALF);
      sck = 1'b0;
    end
    #(HALF);
    mosi = ~mosi;
  endtask

  task automatic start_cond();
    mosi = 1'b1;
    #(HALF);
    sck = 1'b1;
    #(HALF);
    mosi = 1'b0;
    #(HALF);
    sck = 1'b0;
    #(HALF);
  endtask
endmodule

// ==== verif/spi_i2c_serial_shift_port_test.sv ====
// Self-checking bench of the shift port
`timescale 1ns/1ps
`include "shift_port_params.svh"
module spi_i2c_serial_shift_port_test;
  import shift_port_pkg::*;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] expData;
  } row_type;
  typedef struct packed {
    logic [2:0] src;
    logic [1:0] kind;
    logic       cpol;
    logic       tog;
  } clk_row_type;

  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  sfr_req_type sfrReq = '0;
  logic        t0Pulse, t1Pulse, wrPulse;
  logic        twoWire = 1'b0;
  logic        farSck, farMosi, farSelN, sdaLine;
  logic        sckOut, sckOe, dataOut, dataOe, seen, oe, oe2;
  logic        countInterrupt, startStopInterrupt, txReady, portActive;
  logic [7:0]  sfrRdData, rd, rx, rx2;
  int          n_mismatch = 0;
  int          n_tests = 0;
  row_type     rows [9];
  clk_row_type clkRows [6];

  always #2 core_clk = ~core_clk;
  // Joined data pins with open-drain output in two-wire mode
  assign sdaLine = twoWire ? (farMosi & ~(dataOe & ~dataOut)) : farMosi;

  spi_i2c_shift_port #(.FIFO_WIDTH(8), .FIFO_DEPTH(8)) i_dut (
    .core_clk(core_clk), .rst(rst), .sfrReq(sfrReq), .sfrRdData(sfrRdData),
    .timer0OverflowOut(t0Pulse), .timer1OverflowOut(t1Pulse), .externalDataMove(wrPulse),
    .sckIn(farSck), .sckOut(sckOut), .sckOe(sckOe), .dataIn(sdaLine), .dataOut(dataOut),
    .dataOe(dataOe), .slaveSelectIn_n(farSelN), .countInterrupt(countInterrupt),
    .startStopInterrupt(startStopInterrupt), .txReady(txReady), .portActive(portActive));
  spi_far_master i_far (.sck(farSck), .mosi(farMosi), .selN(farSelN), .miso(dataOut),
    .misoOe(dataOe));

  task automatic check(input logic [7:0] got, input logic [7:0] want);
    n_tests++;
    if (got !== want) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask

  task automatic sfr(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge core_clk);
    sfrReq <= '{a, d, w, !w};
    @(posedge core_clk);
    sfrReq <= '0;
    #1 rd = sfrRdData;
  endtask

  task automatic wait_on(ref logic s, input logic want);
    for (int i = 0; i < 40 && s !== want; i++) @(posedge core_clk);
    if (s !== want) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    {t0Pulse, t1Pulse, wrPulse} <= 3'h0;
    rows = '{'{8'h9c, 8'h0f, 8'h0f}, '{8'h9c, 8'h08, 8'h08}, '{8'hf2, 8'h0b, 8'h0b},
             '{8'hf2, 8'h07, 8'h07}, '{8'h9e, 8'h07, 8'h07}, '{8'h9e, 8'h00, 8'h00},
             '{8'hf1, 8'h00, 8'h00}, '{8'h00, 8'ha5, 8'h00}, '{8'h9d, 8'hff, 8'h00}};
    clkRows = '{'{3'h1, 2'h2, 1'h1, 1'h0}, '{3'h2, 2'h2, 1'h0, 1'h1},
                '{3'h3, 2'h0, 1'h0, 1'h0}, '{3'h4, 2'h0, 1'h0, 1'h1},
                '{3'h5, 2'h1, 1'h0, 1'h0}, '{3'h6, 2'h1, 1'h0, 1'h1}};
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      sfr(rows[i].addr, rows[i].wdata, 1'b1);
      sfr(rows[i].addr, 8'h00, 1'b0);
      check(rd, rows[i].expData);
    end
    check({7'h0, dataOe}, 8'h00);
    sfr(`ADDR_SHIFT_DATA, 8'ha5, 1'b1);
    i_far.select(1'b1);
    check({7'h0, dataOe}, 8'h01);
    i_far.exchange(8'h3c, 0, 3, 1'b0, rx, oe);
    sfr(`ADDR_SHIFT_CTRL, 8'h00, 1'b0);
    check(rd, 8'h38);
    i_far.exchange(8'h3c, 3, 5, 1'b0, rx2, oe2);
    check({7'h0, countInterrupt}, 8'h01);
    check(rx | rx2, 8'ha5);
    check({7'h0, oe & oe2}, 8'h01);
    sfr(`ADDR_SHIFT_DATA, 8'h00, 1'b0);
    check(rd, 8'h3c);
    check({7'h0, countInterrupt}, 8'h00);
    i_far.select(1'b0);
    check({7'h0, dataOe}, 8'h00);
    // Clocks while deselected must leave the counter at eight
    i_far.exchange(8'hff, 0, 2, 1'b0, rx, oe);
    sfr(`ADDR_SHIFT_STATUS, 8'h00, 1'b0);
    check(rd, 8'h08);
    i_far.select(1'b1);
    i_far.exchange(8'h5a, 0, 8, 1'b0, rx, oe);
    i_far.exchange(8'hc3, 0, 1, 1'b0, rx, oe);
    check({7'h0, countInterrupt}, 8'h00);
    i_far.exchange(8'hc3, 1, 7, 1'b0, rx, oe);
    sfr(`ADDR_SHIFT_DATA, 8'h00, 1'b0);
    check(rd, 8'hc3);
    sfr(`ADDR_TWO_WIRE_CTRL, 8'h04, 1'b1);
    sfr(`ADDR_SHIFT_DATA, 8'h1e, 1'b1);
    i_far.exchange(8'h96, 0, 8, 1'b1, rx, oe);
    check(rx, 8'h1e);
    sfr(`ADDR_SHIFT_DATA, 8'h00, 1'b0);
    check(rd, 8'h96);
    repeat (12) sfr(`ADDR_SHIFT_DATA, 8'h11, 1'b1);
    check({7'h0, txReady}, 8'h00);
    sfr(`ADDR_SHIFT_STATUS, 8'h00, 1'b0);
    check(rd & 8'h40, 8'h40);
    i_far.exchange(8'h00, 0, 8, 1'b1, rx, oe);
    check(rx, 8'h11);
    check({7'h0, txReady}, 8'h01);
    i_far.select(1'b0);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    sfr(`ADDR_POWER_CTRL, 8'h00, 1'b0);
    check(rd, 8'h01);
    check({3'h0, portActive, sckOe, dataOe, countInterrupt, startStopInterrupt}, 8'h00);
    sfr(`ADDR_POWER_CTRL, 8'h00, 1'b1);
    foreach (clkRows[i]) begin
      sfr(`ADDR_SHIFT_CTRL, {5'h00, 1'b1, 1'b0, clkRows[i].cpol}, 1'b1);
      // Park at the idle level so toggles start from it
      sfr(`ADDR_CLK_SRC_SEL, 8'h07, 1'b1);
      sfr(`ADDR_CLK_SRC_SEL, {5'h00, clkRows[i].src}, 1'b1);
      for (int j = 1; j <= 2; j++) begin
        @(posedge core_clk);
        t0Pulse <= (clkRows[i].kind == 2'h0);
        t1Pulse <= (clkRows[i].kind == 2'h1);
        wrPulse <= (clkRows[i].kind == 2'h2);
        @(posedge core_clk);
        {t0Pulse, t1Pulse, wrPulse} <= 3'h0;
        seen = 1'b0;
        repeat (6) begin
          @(negedge core_clk);
          seen = seen | (sckOut !== clkRows[i].cpol);
        end
        check({6'h0, sckOe, sckOut}, {6'h0, 1'b1, clkRows[i].cpol ^ (clkRows[i].tog & j[0])});
        check({7'h0, seen}, 8'h01);
      end
    end
    sfr(`ADDR_SHIFT_CTRL, 8'h00, 1'b1);
    sfr(`ADDR_CLK_SRC_SEL, 8'h07, 1'b1);
    @(posedge core_clk);
    twoWire <= 1'b1;
    sfr(`ADDR_TWO_WIRE_CTRL, 8'h03, 1'b1);
    i_far.start_cond();
    wait_on(startStopInterrupt, 1'b1);
    sfr(`ADDR_SHIFT_STATUS, 8'h00, 1'b0);
    // Start clears the count; the clock's fall after it counts one
    check(rd & 8'h0f, 8'h01);
    sfr(`ADDR_TWO_WIRE_CTRL, 8'h00, 1'b0);
    check(rd, 8'h03);
    check({7'h0, startStopInterrupt}, 8'h00);
    sfr(`ADDR_TWO_WIRE_DATA, 8'hff, 1'b1);
    i_far.exchange(8'h80, 0, 1, 1'b0, rx, oe);
    check({5'h0, sckOe, sckOut, countInterrupt}, 8'h05);
    sfr(`ADDR_TWO_WIRE_DATA, 8'h7f, 1'b1);
    wait_on(sckOe, 1'b0);
    check({7'h0, countInterrupt}, 8'h00);
    report_and_stop();
  end
endmodule
